//--- src/rtcy_map.svh
// Offsets, field positions, reset values and timing counts of the
// calendar year, control and alarm 0 block.
// Assumes a byte address of eight bits and a 32-bit register bus.
`ifndef RTCY_MAP_SVH
`define RTCY_MAP_SVH

`define RTCY_ADDR_W          8
`define RTCY_OFF_MONTH       8'h14
`define RTCY_OFF_YEAR        8'h18
`define RTCY_OFF_CTRL        8'h1C
`define RTCY_OFF_AL0_MIN     8'h20
`define RTCY_OFF_AL0_HOUR    8'h24
`define RTCY_OFF_AL0_WEEK    8'h28

`define RTCY_CTRL_RUN_BIT    0
`define RTCY_CTRL_SEL_LSB    1
`define RTCY_CTRL_SEL_MSB    2

`define RTCY_YEAR_RESET      8'h00
`define RTCY_MONTH_RESET     5'h01
`define RTCY_AL0_MIN_RESET   7'h00
`define RTCY_AL0_HOUR_RESET  6'h00
`define RTCY_AL0_WEEK_RESET  3'h0
`define RTCY_READ_ZERO       32'h0000_0000

`define RTCY_YEAR_MAX        8'h99
`define RTCY_YEAR_WRAP       8'h00
`define RTCY_MONTH_MAX       8'h12
`define RTCY_MONTH_MIN       8'h01
`define RTCY_MINUTE_MAX      8'h59
`define RTCY_HOUR_MAX        8'h23
`define RTCY_WEEK_ANY        3'h0

// Clock rate in kHz and half-second period in ms
`define RTCY_CLK_KHZ         10000
`define RTCY_HALF_PERIOD_MS  500
`define RTCY_HALF_CYCLES     (`RTCY_HALF_PERIOD_MS * `RTCY_CLK_KHZ)
`define RTCY_TB_W            23

`endif

//--- src/rtcy_pkg.sv
// Types shared by the calendar year, control and alarm 0 block.
// Assumes nothing of its surroundings.
package rtcy_pkg;

    typedef enum logic [1:0] {
        RTCY_PER_OFF  = 2'b00,
        RTCY_PER_HALF = 2'b01,
        RTCY_PER_SEC  = 2'b10,
        RTCY_PER_MIN  = 2'b11
    } rtcy_per_sel_e;

endpackage

//--- src/rtcy_time_base.sv
// Free running time base: half-second and one-hertz ticks.
// Assumes clear is a one-cycle pulse in the clock_in domain.
`timescale 1ns/1ps
`include "rtcy_map.svh"

module rtcy_time_base #(
    parameter int HALF_CYCLES = `RTCY_HALF_CYCLES
) (
    input  wire logic                    clock_in,
    input  wire logic                    reset_in,
    input  wire logic                    clear_in,
    output logic [`RTCY_TB_W-1:0]        count_out,
    output logic                         half_tick_out,
    output logic                         one_hz_out
);
    logic [`RTCY_TB_W-1:0] count_q;
    logic [`RTCY_TB_W-1:0] count_d;
    logic                  phase_q;
    logic                  phase_d;
    logic                  half_q;
    logic                  half_d;
    logic                  hz_q;
    logic                  hz_d;
    logic                  wrap;

    // Keeps running while the clock is stopped so half-second and
    // one-second requests still come out
    always_comb begin
        wrap    = (count_q == `RTCY_TB_W'(HALF_CYCLES - 1));
        count_d = wrap ? '0 : count_q + `RTCY_TB_W'(1);
        phase_d = wrap ? ~phase_q : phase_q;
        half_d  = wrap;
        hz_d    = wrap & phase_q;
        if (clear_in) begin
            count_d = '0;
            phase_d = 1'b0;
            half_d  = 1'b0;
            hz_d    = 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            count_q <= '0;
            phase_q <= 1'b0;
            half_q  <= 1'b0;
            hz_q    <= 1'b0;
        end else begin
            count_q <= count_d;
            phase_q <= phase_d;
            half_q  <= half_d;
            hz_q    <= hz_d;
        end
    end

    assign count_out     = count_q;
    assign half_tick_out = half_q;
    assign one_hz_out    = hz_q;

endmodule

//--- src/rtcy_top.sv
// Calendar year counter, month counter, clock control and alarm 0.
// Assumes minute, hour, weekday and second carry come from counters
// outside, synchronous to clock_in; register strobes are one cycle.
// Operation
// R1: Year holds two BCD digits in bits 7..0, reset 00.
// R2: Year advances by one when month rolls from 12 to 01.
// R3: Writing year also clears the time base counter.
// R4: Software loads year only while the clock is stopped.
// R5: Software rereads year until two reads agree.
// R6: Select field bits 2..1: off, half second, second, minute; reset 00.
// R7: Control bit 0 runs the clock when 1, stops it when 0.
// R8: Half-second and one-second requests come even while stopped.
// R9: One-minute request never comes while stopped; a carry meeting a stop write still raises it in the first stopped cycle.
// R10: Stopping the clock suppresses a coinciding seconds increment.
// R11: Run bit reads zero within one cycle after writing zero.
// R12: Software stops and polls run bit before reconfiguring.
// R13: Software programs registers and clears interrupts before start.
// R14: Alarm minute holds BCD 00..59 in bits 6..0, reset 00.
// R15: Alarm hour holds BCD 00..23 in bits 5..0, reset 00.
// R16: Impossible alarm compare values never raise the alarm.
// R17: Alarm weekday holds 0..7 in bits 2..0, reset 0.
// R18: Alarm weekday zero matches every day.
// R19: Month holds BCD 01..12 and supplies the year rollover.
// R20: Alarm raised once when minute, hour and weekday all match.
// R21: Periodic requests derive from time base and seconds rollover.
`timescale 1ns/1ps
`include "rtcy_map.svh"

module rtcy_top #(
    parameter int HALF_CYCLES = `RTCY_HALF_CYCLES
) (
    input  wire logic                    clock_in,
    input  wire logic                    reset_in,
    input  wire logic [`RTCY_ADDR_W-1:0] addr_in,
    input  wire logic [31:0]             wr_data_in,
    input  wire logic                    wr_in,
    input  wire logic                    rd_in,
    input  wire logic                    day_carry_in,
    input  wire logic                    sec_carry_in,
    input  wire logic                    tb_clear_in,
    input  wire logic [6:0]              minute_in,
    input  wire logic [5:0]              hour_in,
    input  wire logic [2:0]              weekday_in,
    output logic [31:0]                  rd_data_out,
    output logic                         clock_run_out,
    output logic                         second_inc_out,
    output logic                         periodic_irq_out,
    output logic                         alarm_zero_irq_out
);

    function automatic logic [7:0] bcd_next(input logic [7:0] v,
                                            input logic [7:0] max,
                                            input logic [7:0] wrap);
        if (v == max)
            return wrap;
        else if (v[3:0] == 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        else
            return {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic bcd_ok(input logic [7:0] v,
                                    input logic [7:0] max);
        return (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9) && (v <= max);
    endfunction

    // Register state
    logic [7:0]                 year_q;
    logic [7:0]                 year_d;
    logic [4:0]                 month_q;
    logic [4:0]                 month_d;
    logic                       run_q;
    logic                       run_d;
    rtcy_pkg::rtcy_per_sel_e    sel_q;
    rtcy_pkg::rtcy_per_sel_e    sel_d;
    logic [6:0]                 al_min_q;
    logic [6:0]                 al_min_d;
    logic [5:0]                 al_hour_q;
    logic [5:0]                 al_hour_d;
    logic [2:0]                 al_week_q;
    logic [2:0]                 al_week_d;
    logic [31:0]                rd_q;
    logic [31:0]                rd_d;

    // Event state
    logic                       sec_inc_q;
    logic                       sec_inc_d;
    logic                       per_q;
    logic                       per_d;
    logic                       match_q;
    logic                       match_d;
    logic                       alarm_q;
    logic                       alarm_d;

    // Decode and helpers
    logic                       wr_year;
    logic                       wr_month;
    logic                       wr_ctrl;
    logic                       tb_clear;
    logic                       month_roll;
    logic                       alarm_valid;
    logic                       alarm_equal;
    logic [`RTCY_TB_W-1:0]      tb_count;
    logic                       half_tick;
    logic                       one_hz;

    assign wr_year  = wr_in && (addr_in == `RTCY_OFF_YEAR);
    assign wr_month = wr_in && (addr_in == `RTCY_OFF_MONTH);
    assign wr_ctrl  = wr_in && (addr_in == `RTCY_OFF_CTRL);
    // Calendar writes restart the second so the new time is exact
    assign tb_clear = wr_year || wr_month || tb_clear_in; // R3

    rtcy_time_base #(
        .HALF_CYCLES (HALF_CYCLES)
    ) u_time_base (
        .clock_in      (clock_in),
        .reset_in      (reset_in),
        .clear_in      (tb_clear),
        .count_out     (tb_count),
        .half_tick_out (half_tick),
        .one_hz_out    (one_hz)
    );

    // Calendar and control registers
    always_comb begin
        month_roll = run_q && day_carry_in
                     && ({3'h0, month_q} == `RTCY_MONTH_MAX); // R19
        year_d    = year_q;
        month_d   = month_q;
        run_d     = run_q;
        sel_d     = sel_q;
        al_min_d  = al_min_q;
        al_hour_d = al_hour_q;
        al_week_d = al_week_q;
        if (run_q && day_carry_in) begin
            // Top bits of the result stay zero for a legal month
            month_d = 5'(bcd_next({3'h0, month_q}, `RTCY_MONTH_MAX,
                                  `RTCY_MONTH_MIN)); // R19
        end
        if (month_roll) begin
            year_d = bcd_next(year_q, `RTCY_YEAR_MAX,
                              `RTCY_YEAR_WRAP); // R2
        end
        if (wr_in) begin
            case (addr_in)
                `RTCY_OFF_YEAR: begin
                    year_d = wr_data_in[7:0]; // R1
                end
                `RTCY_OFF_MONTH: begin
                    month_d = wr_data_in[4:0];
                end
                `RTCY_OFF_CTRL: begin
                    run_d = wr_data_in[`RTCY_CTRL_RUN_BIT]; // R7 R11
                    sel_d = rtcy_pkg::rtcy_per_sel_e'(
                        wr_data_in[`RTCY_CTRL_SEL_MSB:`RTCY_CTRL_SEL_LSB]);
                end
                `RTCY_OFF_AL0_MIN: begin
                    al_min_d = wr_data_in[6:0]; // R14
                end
                `RTCY_OFF_AL0_HOUR: begin
                    al_hour_d = wr_data_in[5:0]; // R15
                end
                `RTCY_OFF_AL0_WEEK: begin
                    al_week_d = wr_data_in[2:0]; // R17
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            year_q    <= `RTCY_YEAR_RESET;
            month_q   <= `RTCY_MONTH_RESET;
            run_q     <= 1'b0;
            sel_q     <= rtcy_pkg::RTCY_PER_OFF;
            al_min_q  <= `RTCY_AL0_MIN_RESET;
            al_hour_q <= `RTCY_AL0_HOUR_RESET;
            al_week_q <= `RTCY_AL0_WEEK_RESET;
        end else begin
            year_q    <= year_d;
            month_q   <= month_d;
            run_q     <= run_d;
            sel_q     <= sel_d;
            al_min_q  <= al_min_d;
            al_hour_q <= al_hour_d;
            al_week_q <= al_week_d;
        end
    end

    // Read path, data in the cycle after the strobe
    always_comb begin
        rd_d = `RTCY_READ_ZERO;
        if (rd_in) begin
            case (addr_in)
                `RTCY_OFF_YEAR:     rd_d[7:0] = year_q;
                `RTCY_OFF_MONTH:    rd_d[4:0] = month_q;
                `RTCY_OFF_CTRL:     rd_d[2:0] = {sel_q, run_q};
                `RTCY_OFF_AL0_MIN:  rd_d[6:0] = al_min_q;
                `RTCY_OFF_AL0_HOUR: rd_d[5:0] = al_hour_q;
                `RTCY_OFF_AL0_WEEK: rd_d[2:0] = al_week_q;
                default:            rd_d = `RTCY_READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rd_q <= `RTCY_READ_ZERO;
        end else begin
            rd_q <= rd_d;
        end
    end

    // Events: seconds advance, periodic request, alarm 0
    always_comb begin
        // Next run value gates the tick, so a stop write wins
        sec_inc_d = one_hz && run_q && run_d; // R10
        case (sel_q)
            rtcy_pkg::RTCY_PER_OFF:  per_d = 1'b0; // R6
            rtcy_pkg::RTCY_PER_HALF: per_d = half_tick; // R8 R21
            rtcy_pkg::RTCY_PER_SEC:  per_d = one_hz; // R8 R21
            rtcy_pkg::RTCY_PER_MIN:  per_d = sec_carry_in && run_q; // R9
            default:                 per_d = 1'b0;
        endcase
        alarm_valid = bcd_ok({1'b0, al_min_q}, `RTCY_MINUTE_MAX)
                      && bcd_ok({2'h0, al_hour_q}, `RTCY_HOUR_MAX); // R16
        alarm_equal = (minute_in == al_min_q) && (hour_in == al_hour_q)
                      && ((al_week_q == `RTCY_WEEK_ANY)
                          || (weekday_in == al_week_q)); // R18
        match_d = run_q && alarm_valid && alarm_equal;
        // Edge only: a match lasts a whole minute
        alarm_d = match_d && !match_q; // R20
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            sec_inc_q <= 1'b0;
            per_q     <= 1'b0;
            match_q   <= 1'b0;
            alarm_q   <= 1'b0;
        end else begin
            sec_inc_q <= sec_inc_d;
            per_q     <= per_d;
            match_q   <= match_d;
            alarm_q   <= alarm_d;
        end
    end

    assign rd_data_out        = rd_q;
    assign clock_run_out      = run_q;
    assign second_inc_out     = sec_inc_q;
    assign periodic_irq_out   = per_q;
    assign alarm_zero_irq_out = alarm_q;

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    sequence stop_write_s;
        wr_ctrl && !wr_data_in[`RTCY_CTRL_RUN_BIT];
    endsequence

    sequence month_wrap_s;
        run_q && day_carry_in && (month_q == 5'h12) && !wr_in;
    endsequence

    chk_year_advance: assert property ( // R2
        month_wrap_s |=> year_q == bcd_next($past(year_q), 8'h99, 8'h00))
        else $error("year did not advance on month wrap");

    chk_month_wrap: assert property ( // R19
        month_wrap_s |=> month_q == 5'h01)
        else $error("month did not wrap to one");

    chk_year_clears_tb: assert property ( // R3
        wr_year |=> tb_count == '0)
        else $error("year write did not clear time base");

    chk_run_stops: assert property ( // R11
        stop_write_s |=> !clock_run_out)
        else $error("run bit not zero after stop write");

    chk_stop_no_inc: assert property ( // R10
        stop_write_s |=> !second_inc_out)
        else $error("seconds advanced on stop");

    chk_half_stopped: assert property ( // R8
        (sel_q == rtcy_pkg::RTCY_PER_HALF) && half_tick && !wr_ctrl
        |=> periodic_irq_out)
        else $error("half second request missing");

    chk_min_stopped: assert property ( // R9
        (sel_q == rtcy_pkg::RTCY_PER_MIN) && !run_q |=> !periodic_irq_out)
        else $error("minute request while stopped");

    chk_alarm_invalid: assert property ( // R16
        !alarm_valid |=> !alarm_zero_irq_out)
        else $error("alarm from impossible setting");

    chk_alarm_once: assert property ( // R20
        alarm_zero_irq_out |=> !alarm_zero_irq_out [*2])
        else $error("alarm raised twice");

    chk_week_any: assert property ( // R18
        run_q && alarm_valid && (al_week_q == 3'h0) && !match_q
        && (minute_in == al_min_q) && (hour_in == al_hour_q)
        |=> alarm_zero_irq_out)
        else $error("weekday zero did not match");

    chk_per_off: assert property ( // R6
        sel_q == rtcy_pkg::RTCY_PER_OFF |=> !periodic_irq_out)
        else $error("periodic request while disabled");

    chk_sec_request: assert property ( // R8
        (sel_q == rtcy_pkg::RTCY_PER_SEC) && one_hz |=> periodic_irq_out)
        else $error("one second request missing");

    chk_sec_stopped: assert property ( // R7
        !run_q |=> !second_inc_out)
        else $error("seconds advanced while stopped");

    chk_sec_tick: assert property ( // R21
        one_hz && run_q && !wr_ctrl |=> second_inc_out)
        else $error("seconds missed a tick");

    chk_cal_hold: assert property ( // R7
        !run_q && !wr_in |=> $stable(year_q) && $stable(month_q))
        else $error("calendar moved while stopped");

    chk_alarm_stopped: assert property ( // R20
        !run_q |=> !alarm_zero_irq_out)
        else $error("alarm raised while stopped");

    chk_week_other: assert property ( // R18
        (al_week_q != 3'h0) && (weekday_in != al_week_q)
        |=> !alarm_zero_irq_out)
        else $error("alarm on another weekday");

    chk_clear_input: assert property ( // R3
        tb_clear_in |=> tb_count == '0)
        else $error("time base not cleared");

endmodule

//--- verif/calendar_year_control_alarm0_tb.sv
// Self-checking bench for the calendar year, control and alarm 0 block.
// Assumes rtcy_top with a shortened half-second count; no partner model.
`timescale 1ns/1ps
`include "rtcy_map.svh"

module calendar_year_control_alarm0_tb;
    localparam int HC = 8;
    localparam logic [7:0] OFF [5] = '{`RTCY_OFF_YEAR, `RTCY_OFF_CTRL,
        `RTCY_OFF_AL0_MIN, `RTCY_OFF_AL0_HOUR, `RTCY_OFF_AL0_WEEK};
    localparam logic [31:0] MSK [5] = '{32'h0000_00FF, 32'h0000_0006,
        32'h0000_007F, 32'h0000_003F, 32'h0000_0007};

    logic                    clock_in;
    logic                    reset_in;
    logic [`RTCY_ADDR_W-1:0] addr_in;
    logic [31:0]             wr_data_in;
    logic                    wr_in;
    logic                    rd_in;
    logic                    day_carry_in;
    logic                    sec_carry_in;
    logic                    tb_clear_in;
    logic [6:0]              minute_in;
    logic [5:0]              hour_in;
    logic [2:0]              weekday_in;
    logic [31:0]             rd_data_out;
    logic                    clock_run_out;
    logic                    second_inc_out;
    logic                    periodic_irq_out;
    logic                    alarm_zero_irq_out;
    int                      errors;
    int                      compares;
    int                      n_per;
    int                      n_sec;
    int                      n_al;
    logic [31:0]             d;

    rtcy_top #(.HALF_CYCLES(HC)) i_dut (
        .clock_in           (clock_in),
        .reset_in           (reset_in),
        .addr_in            (addr_in),
        .wr_data_in         (wr_data_in),
        .wr_in              (wr_in),
        .rd_in              (rd_in),
        .day_carry_in       (day_carry_in),
        .sec_carry_in       (sec_carry_in),
        .tb_clear_in        (tb_clear_in),
        .minute_in          (minute_in),
        .hour_in            (hour_in),
        .weekday_in         (weekday_in),
        .rd_data_out        (rd_data_out),
        .clock_run_out      (clock_run_out),
        .second_inc_out     (second_inc_out),
        .periodic_irq_out   (periodic_irq_out),
        .alarm_zero_irq_out (alarm_zero_irq_out)
    );

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    // Pulses are counted at the edge that ends their one-cycle stand
    always @(posedge clock_in) begin
        if (periodic_irq_out === 1'b1) n_per++;
        if (second_inc_out === 1'b1) n_sec++;
        if (alarm_zero_irq_out === 1'b1) n_al++;
    end

    task automatic tally_and_finish;
        if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_in);
        addr_in    <= a;
        wr_data_in <= v;
        wr_in      <= 1'b1;
        @(posedge clock_in);
        wr_in      <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in   <= 1'b0;
        #1;
        check(rd_data_out, exp);
    endtask

    task automatic zero_cnt;
        @(negedge clock_in);
        n_per = 0;
        n_sec = 0;
        n_al  = 0;
    endtask

    // Stop first, then confirm the run bit reads back low
    task automatic stop_clock;
        wr(`RTCY_OFF_CTRL, 32'h0000_0000);
        rd_chk(`RTCY_OFF_CTRL, 32'h0000_0000);
        check({31'h0, clock_run_out}, 32'h0000_0000);
    endtask

    // Model of periodic request counts over a window of win cycles
    function automatic int exp_per(int sel, int run, int win, int carries);
        case (sel)
            1: return win / HC;
            2: return win / (2 * HC);
            3: return run ? carries : 0;
            default: return 0;
        endcase
    endfunction

    task automatic cal_case(input logic [7:0] mo, input logic [7:0] yr,
                            input logic run, input logic [7:0] emo,
                            input logic [7:0] eyr);
        stop_clock();
        wr(`RTCY_OFF_MONTH, {24'h0, mo});
        wr(`RTCY_OFF_YEAR, {24'h0, yr});
        wr(`RTCY_OFF_CTRL, {31'h0, run});
        @(posedge clock_in) day_carry_in <= 1'b1;
        @(posedge clock_in) day_carry_in <= 1'b0;
        rd_chk(`RTCY_OFF_MONTH, {24'h0, emo});
        rd_chk(`RTCY_OFF_YEAR, {24'h0, eyr});
        rd_chk(`RTCY_OFF_YEAR, {24'h0, eyr});
    endtask

    task automatic alarm_case(input logic [6:0] am, input logic [5:0] ah,
                              input logic [2:0] aw, input logic [6:0] im,
                              input logic [5:0] ih, input logic [2:0] iw,
                              input int e);
        @(posedge clock_in) minute_in <= 7'h01;
        wr(`RTCY_OFF_AL0_MIN, {25'h0, am});
        wr(`RTCY_OFF_AL0_HOUR, {26'h0, ah});
        wr(`RTCY_OFF_AL0_WEEK, {29'h0, aw});
        zero_cnt();
        @(posedge clock_in);
        minute_in  <= im;
        hour_in    <= ih;
        weekday_in <= iw;
        repeat (8) @(posedge clock_in);
        @(negedge clock_in);
        check(n_al, e);
    endtask

    initial begin
        repeat (20000) @(posedge clock_in);
        errors++;
        tally_and_finish();
    end

    initial begin
        errors = 0; compares = 0; n_per = 0; n_sec = 0; n_al = 0;
        reset_in = 1'b1; addr_in = 8'h00; wr_data_in = 32'h0000_0000;
        wr_in = 1'b0; rd_in = 1'b0; day_carry_in = 1'b0;
        sec_carry_in = 1'b0; tb_clear_in = 1'b0; minute_in = 7'h01;
        hour_in = 6'h00; weekday_in = 3'h1;
        void'($urandom(32'haed34827));
        repeat (10) @(posedge clock_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 5; i++)
            rd_chk(OFF[i], 32'h0000_0000);
        rd_chk(`RTCY_OFF_MONTH, 32'h0000_0001);
        rd_chk(8'h40, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            d = $urandom & 32'hFFFF_FFFE;
            wr(OFF[i], d);
            rd_chk(OFF[i], d & MSK[i]);
        end
        wr(`RTCY_OFF_CTRL, 32'h0000_0001);
        // Run bit settles after the edge that takes the write
        @(negedge clock_in);
        check({31'h0, clock_run_out}, 32'h0000_0001);
        cal_case(8'h12, 8'h99, 1'b1, 8'h01, 8'h00);
        cal_case(8'h12, 8'h09, 1'b1, 8'h01, 8'h10);
        cal_case(8'h05, 8'h49, 1'b1, 8'h06, 8'h49);
        cal_case(8'h12, 8'h49, 1'b0, 8'h12, 8'h49);
        for (int run = 0; run < 2; run++) begin
            for (int sel = 0; sel < 4; sel++) begin
                stop_clock();
                wr(`RTCY_OFF_CTRL, 32'(sel * 2 + run));
                repeat (2) @(posedge clock_in);
                zero_cnt();
                repeat (4) begin
                    @(posedge clock_in) sec_carry_in <= 1'b1;
                    @(posedge clock_in) sec_carry_in <= 1'b0;
                    repeat (14) @(posedge clock_in);
                end
                @(negedge clock_in);
                check(n_per, exp_per(sel, run, 64, 4));
                check(n_sec, run ? 64 / (2 * HC) : 0);
            end
        end
        // Clearing every six cycles keeps the half tick from arriving
        stop_clock();
        wr(`RTCY_OFF_CTRL, 32'h0000_0002);
        // First clear fixes the phase; a tick already in flight drains
        wr(`RTCY_OFF_YEAR, 32'h0000_0021);
        repeat (2) @(posedge clock_in);
        zero_cnt();
        for (int i = 0; i < 10; i++) begin
            if (i % 2 == 0) wr(`RTCY_OFF_YEAR, 32'h0000_0021);
            else begin
                @(posedge clock_in) tb_clear_in <= 1'b1;
                @(posedge clock_in) tb_clear_in <= 1'b0;
            end
            repeat (4) @(posedge clock_in);
        end
        @(negedge clock_in);
        check(n_per, 0);
        stop_clock();
        wr(`RTCY_OFF_CTRL, 32'h0000_0001);
        alarm_case(7'h30, 6'h12, 3'h0, 7'h30, 6'h12,
                   3'(1 + $urandom % 7), 1);
        alarm_case(7'h30, 6'h12, 3'h3, 7'h30, 6'h12, 3'h4, 0);
        alarm_case(7'h30, 6'h12, 3'h3, 7'h30, 6'h12, 3'h3, 1);
        alarm_case(7'h59, 6'h23, 3'h7, 7'h59, 6'h23, 3'h7, 1);
        alarm_case(7'h5A, 6'h12, 3'h0, 7'h5A, 6'h12, 3'h1, 0);
        alarm_case(7'h30, 6'h24, 3'h0, 7'h30, 6'h24, 3'h1, 0);
        tally_and_finish();
    end
endmodule
